// >>> design/cal_correct.sv
// Shared constants and the offset/gain correction stage
`default_nettype none

package filt_pkg;
  localparam int DATA_W       = 24;
  localparam int ADDR_W       = 8;
  localparam int COEF_W       = 16;
  localparam int FIR_TAPS     = 22;
  localparam int FIR_SHIFT    = 16;
  localparam int MAX_AVG      = 16;
  localparam int GAIN_FRAC    = 23;
  localparam int CORR_W       = 33;
  localparam int FULL_SCALE   = 2 ** DATA_W;
  localparam int STEP_PERCENT = 1;
  localparam logic [DATA_W-1:0] STEP_THRESH = DATA_W'(FULL_SCALE / 100 * STEP_PERCENT);
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_FILTER = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_GAIN   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h14;
  // Filter register fields
  localparam int FLT_STEP_BIT   = 0;
  localparam int FLT_BYPASS_BIT = 1;
  localparam int FLT_CHOP_BIT   = 2;
  localparam int FLT_WIDE_BIT   = 3;
  localparam logic [3:0] FILTER_RST = 4'hc;
  // Mode register fields
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_CH_BIT = 4;
  // Operating codes
  localparam logic [2:0] OP_IDLE     = 3'h0;
  localparam logic [2:0] OP_CONT     = 3'h1;
  localparam logic [2:0] OP_SINGLE   = 3'h2;
  localparam logic [2:0] OP_INT_ZERO = 3'h4;
  localparam logic [2:0] OP_INT_FULL = 3'h5;
  localparam logic [2:0] OP_SYS_ZERO = 3'h6;
  localparam logic [2:0] OP_SYS_FULL = 3'h7;
  // Calibration lengths in output periods
  localparam int CAL_LEN_CHOP   = 22;
  localparam int CAL_LEN_NOCHOP = 24;
  localparam logic [DATA_W-1:0] OFFSET_RST = 24'h000000;
  localparam logic [DATA_W-1:0] GAIN_RST   = 24'h800000;
  // Averaging ramp after the step has settled
  localparam logic [3:0] RAMP_COUNT [4] = '{4'h2, 4'h4, 4'h8, 4'h6};
  localparam logic [2:0] RAMP_SHIFT [4] = '{3'h1, 3'h2, 3'h3, 3'h4};

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } sample_t;

  // Fields listed from bit 3 down to bit 0 of the filter register
  typedef struct packed {
    logic wide_result;
    logic chop_enable;
    logic bypass;
    logic step_accel_en;
  } filt_cfg_t;
endpackage

module cal_correct
  import filt_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire sample_t           raw,
  input  wire logic [DATA_W-1:0] offset,
  input  wire logic [DATA_W-1:0] gain,
  input  wire logic              wide_result,
  output sample_t                corrected
);
  logic signed [CORR_W-1:0]      diff_s;
  logic signed [CORR_W+DATA_W:0] prod_s;
  logic signed [CORR_W+1:0]      norm_s;
  logic [DATA_W-1:0]             clamp_w;
  logic [DATA_W-1:0]             sized_w;
  sample_t                       out_q;

  // Offset comes off first, then the gain scales; 1.0 is the gain's top bit
  assign diff_s  = $signed({9'h000, raw.data}) - $signed({9'h000, offset});
  assign prod_s  = diff_s * $signed({1'b0, gain});
  assign norm_s  = prod_s[CORR_W+DATA_W:GAIN_FRAC];
  assign clamp_w = norm_s < 0 ? '0 :
                   norm_s >= FULL_SCALE ? {DATA_W{1'b1}} : norm_s[DATA_W-1:0];
  assign sized_w = wide_result ? clamp_w : {8'h00, clamp_w[DATA_W-1:8]};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_q <= '0;
    else
    begin
      out_q.valid <= raw.valid;
      // Data holds between results so the host may read it late
      if (raw.valid)
        out_q.data <= sized_w;
    end
  end

  assign corrected = out_q;
endmodule // cal_correct

`default_nettype wire

// >>> design/second_stage_filter.sv
// Second-stage filter with step acceleration, bypass and calibration control
`default_nettype none

module second_stage_filter
  import filt_pkg::*;
#(
  parameter int                       CHANNELS = 2,
  parameter logic [COEF_W-1:0]        FIR_COEF [FIR_TAPS] = '{default: 16'h0ba3}
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire sample_t           stage1,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wstrobe,
  input  wire logic              rstrobe,
  output logic [31:0]            rdata,
  output sample_t                result,
  output logic                   step_settling_flag,
  output logic                   cal_busy
);
  typedef enum logic [1:0] {ST_FIR, ST_HOLD, ST_RAMP} step_state_t;

  if (CHANNELS < 1 || CHANNELS > 2)
  begin : g_bad_channels
    $error("CHANNELS must be 1 or 2");
  end

  logic                rst_meta_q;
  logic                rst_sync_q;
  filt_cfg_t           cfg_q;
  logic [2:0]          op_q;
  logic [2:0]          op_d;
  logic                chan_q;
  logic [DATA_W-1:0]   offset_q [CHANNELS];
  logic [DATA_W-1:0]   gain_q [CHANNELS];
  logic [DATA_W-1:0]   hist_q [MAX_AVG+FIR_TAPS];
  step_state_t         state_q;
  step_state_t         state_d;
  logic [1:0]          ramp_q;
  logic [1:0]          ramp_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [5:0]          cal_cnt_q;
  logic                cal_half_q;
  logic [DATA_W-1:0]   result_q;
  logic [31:0]         rdata_q;
  logic                flag_q;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Register decode
  wire wr_filter = wstrobe && addr == REG_FILTER;
  wire wr_mode   = wstrobe && addr == REG_MODE;
  wire wr_offset = wstrobe && addr == REG_OFFSET;
  wire wr_gain   = wstrobe && addr == REG_GAIN;
  wire cal_zero  = op_q == OP_INT_ZERO || op_q == OP_SYS_ZERO ||
                   (op_q == OP_INT_FULL && !cal_half_q);
  wire cal_full  = op_q == OP_SYS_FULL || (op_q == OP_INT_FULL && cal_half_q);
  wire calibrating = op_q[2];
  wire converting  = op_q == OP_CONT || op_q == OP_SINGLE;

  // Step detection against the sample two periods back
  wire [DATA_W-1:0] prev2 = hist_q[1];
  wire [DATA_W-1:0] abs_diff = stage1.data >= prev2 ? stage1.data - prev2
                                                    : prev2 - stage1.data;
  wire step_seen = abs_diff > STEP_THRESH;
  wire accel_on  = cfg_q.step_accel_en && !cfg_q.bypass;

  always_comb
  begin
    state_d = state_q;
    ramp_d  = ramp_q;
    cnt_d   = cnt_q;
    if (!accel_on)
      state_d = ST_FIR;
    else if (step_seen)
    begin
      state_d = ST_HOLD;
      ramp_d  = 2'h0;
      cnt_d   = 4'h0;
    end
    else
    begin
      case (state_q)
        ST_FIR:
          state_d = ST_FIR;
        ST_HOLD:
        begin
          state_d = ST_RAMP;
          ramp_d  = 2'h0;
          cnt_d   = 4'h1;
        end
        ST_RAMP:
        begin
          if (cnt_q == RAMP_COUNT[ramp_q])
          begin
            cnt_d = 4'h1;
            if (ramp_q == 2'h3)
              state_d = ST_FIR;
            else
              ramp_d = ramp_q + 2'h1;
          end
          else
            cnt_d = cnt_q + 4'h1;
        end
        default:
          state_d = ST_FIR;
      endcase
    end
  end

  // Averaging length follows the state this sample moves into
  wire [2:0] avg_shift = state_d == ST_RAMP ? RAMP_SHIFT[ramp_d]
                                            : {2'h0, cfg_q.chop_enable};

  // Window: current sample then history
  logic [DATA_W+4:0]      avg_sum;
  logic [DATA_W+COEF_W+4:0] fir_sum;
  logic [DATA_W-1:0]      win [MAX_AVG+FIR_TAPS];

  always_comb
  begin
    avg_sum = '0;
    fir_sum = '0;
    for (int k = 0; k < MAX_AVG + FIR_TAPS; k++)
      win[k] = k == 0 ? stage1.data : hist_q[k-1];
    for (int k = 0; k < MAX_AVG; k++)
      if (k < (1 << avg_shift))
        avg_sum = avg_sum + (DATA_W+5)'(win[k]);
    for (int k = 0; k < FIR_TAPS; k++)
      fir_sum = fir_sum + (DATA_W+COEF_W+5)'(win[k]) * (DATA_W+COEF_W+5)'(FIR_COEF[k]);
  end

  wire [DATA_W+4:0] avg_shifted = avg_sum >> avg_shift;
  wire [DATA_W+COEF_W+4:0] fir_shifted = fir_sum >> FIR_SHIFT;
  wire [DATA_W-1:0] avg_out = avg_shifted[DATA_W-1:0];
  wire [DATA_W-1:0] fir_out = fir_shifted[DATA_W-1:0];
  wire [DATA_W-1:0] filt_out = cfg_q.bypass      ? stage1.data :
                               state_d == ST_FIR ? fir_out     : avg_out;

  // Calibration sequencing, one coefficient per phase
  wire [5:0] cal_len = cfg_q.chop_enable ? 6'(CAL_LEN_CHOP) : 6'(CAL_LEN_NOCHOP);
  wire cal_step_done = calibrating && stage1.valid && cal_cnt_q == cal_len - 6'h1;
  wire cal_done = cal_step_done && (op_q != OP_INT_FULL || cal_half_q);

  always_comb
  begin
    op_d = op_q;
    if (wr_mode)
      op_d = wdata[MODE_OP_LSB +: 3];
    else if (cal_done || (op_q == OP_SINGLE && stage1.valid))
      op_d = OP_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      cfg_q  <= FILTER_RST;
      op_q   <= OP_IDLE;
      chan_q <= 1'b0;
    end
    else
    begin
      if (wr_filter)
        cfg_q <= wdata[3:0];
      if (wr_mode)
        chan_q <= wdata[MODE_CH_BIT] && CHANNELS > 1;
      op_q <= op_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      cal_cnt_q  <= '0;
      cal_half_q <= 1'b0;
    end
    else if (wr_mode || !calibrating)
    begin
      cal_cnt_q  <= '0;
      cal_half_q <= 1'b0;
    end
    else if (stage1.valid)
    begin
      cal_cnt_q <= cal_step_done ? 6'h00 : cal_cnt_q + 6'h01;
      if (cal_step_done)
        cal_half_q <= 1'b1;
    end
  end

  // Coefficient store; a completed calibration step wins over an offset or gain write, a mode write in the same cycle cancels it
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_coef
    wire sel = chan_q == c[0];
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
      if (!rst_sync_q)
      begin
        offset_q[c] <= OFFSET_RST;
        gain_q[c]   <= GAIN_RST;
      end
      else
      begin
        if (sel && cal_step_done && cal_zero && !wr_mode)
          offset_q[c] <= filt_out;
        else if (sel && wr_offset)
          offset_q[c] <= wdata[DATA_W-1:0];
        if (sel && cal_step_done && cal_full && !wr_mode)
          gain_q[c] <= filt_out;
        else if (sel && wr_gain)
          gain_q[c] <= wdata[DATA_W-1:0];
      end
    end
  end

  // Sample history and step state advance once per first-stage output
  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      state_q <= ST_FIR;
      ramp_q  <= 2'h0;
      cnt_q   <= 4'h0;
      flag_q  <= 1'b0;
      for (int k = 0; k < MAX_AVG + FIR_TAPS; k++)
        hist_q[k] <= '0;
    end
    else if (stage1.valid)
    begin
      state_q <= state_d;
      ramp_q  <= ramp_d;
      cnt_q   <= cnt_d;
      flag_q  <= state_d != ST_FIR;
      for (int k = 0; k < MAX_AVG + FIR_TAPS; k++)
        hist_q[k] <= win[k];
    end
  end

  // Correction applies to converted results only
  sample_t corr_in;
  sample_t corr_out;
  assign corr_in = '{valid: stage1.valid && converting, data: filt_out};

  cal_correct u_correct (
    .sys_clk     (sys_clk),
    .rst_n       (rst_sync_q),
    .raw         (corr_in),
    .offset      (offset_q[chan_q]),
    .gain        (gain_q[chan_q]),
    .wide_result (cfg_q.wide_result),
    .corrected   (corr_out)
  );

  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      result_q <= '0;
    else if (corr_out.valid)
      result_q <= corr_out.data;
  end

  // Read path: data stands only in the cycle after the strobe
  wire [31:0] rd_mux =
    addr == REG_FILTER ? {28'h0000000, cfg_q} :
    addr == REG_MODE   ? {27'h0000000, chan_q, 1'b0, op_q} :
    addr == REG_STATUS ? {30'h00000000, calibrating, flag_q} :
    addr == REG_OFFSET ? {8'h00, offset_q[chan_q]} :
    addr == REG_GAIN   ? {8'h00, gain_q[chan_q]} :
    addr == REG_RESULT ? {8'h00, result_q} : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      rdata_q <= '0;
    else
      rdata_q <= rstrobe ? rd_mux : 32'h00000000;
  end

  assign rdata              = rdata_q;
  assign result             = corr_out;
  assign step_settling_flag = flag_q;
  assign cal_busy           = calibrating;
endmodule // second_stage_filter

`default_nettype wire

// >>> tb/second_stage_filter_asserts.sv
// Port-level checker for the second-stage filter, bound to its top module
`default_nettype none

module second_stage_filter_asserts
  import filt_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire sample_t           stage1,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic              wstrobe,
  input wire logic              rstrobe,
  input wire logic [31:0]       rdata,
  input wire sample_t           result,
  input wire logic              step_settling_flag,
  input wire logic              cal_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_cal_write;
    wstrobe && addr == REG_MODE && wdata[2];
  endsequence
  sequence s_quiet_busy;
    cal_busy && !stage1.valid && !wstrobe;
  endsequence

  a_cal_start: assert property (s_cal_write |=> cal_busy)
    else $error("calibration did not start on mode write");
  a_cal_hold: assert property (s_quiet_busy |=> cal_busy)
    else $error("calibration ended without a sample");
  a_cal_quiet: assert property (cal_busy && stage1.valid |=> !result.valid)
    else $error("result produced during calibration");
  a_result_cause: assert property (result.valid |-> $past(stage1.valid))
    else $error("result without a first-stage sample");
  a_result_held: assert property (!$past(stage1.valid) |-> $stable(result.data))
    else $error("result data changed between samples");
  a_flag_cause: assert property ($changed(step_settling_flag) |-> $past(stage1.valid))
    else $error("settling flag moved without a sample");
  a_rdata_idle: assert property (rdata != 32'h0 |-> $past(rstrobe))
    else $error("read data outside the read answer cycle");
  a_status_read: assert property (rstrobe && addr == REG_STATUS |=>
    rdata == {30'h0, $past(cal_busy), $past(step_settling_flag)})
    else $error("status read mismatch");
endmodule // second_stage_filter_asserts

bind second_stage_filter second_stage_filter_asserts chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .stage1(stage1), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
  .rstrobe(rstrobe), .rdata(rdata), .result(result),
  .step_settling_flag(step_settling_flag), .cal_busy(cal_busy));

`default_nettype wire

// >>> tb/second_stage_filter_tb_top.sv
// Self-checking testbench for the second-stage filter
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module second_stage_filter_tb_top;
  import filt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  cfgs [6]    = '{4'hd, 4'hd, 4'h9, 4'hd, 4'hd, 4'hc};
  localparam logic [23:0] deltas [6]  = '{24'h030000, 24'hfd0000, 24'h030000,
                                          STEP_THRESH, STEP_THRESH + 24'h1, 24'h030000};
  localparam int          nflag [6]   = '{22, 22, 22, 0, 22, 0};
  localparam logic [2:0]  cal_ops [4] = '{OP_SYS_ZERO, OP_SYS_FULL, OP_INT_FULL, OP_INT_ZERO};
  localparam int          cal_len [4] = '{22, 24, 44, 24};
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] addr    = 8'h00;
  logic [31:0]       wdata   = 32'h0;
  logic              wstrobe = 1'b0;
  logic              rstrobe = 1'b0;
  logic [DATA_W-1:0] level   = 24'h0;
  logic [31:0]       rdata;
  sample_t           stage1;
  sample_t           result;
  sample_t           res;
  logic              step_settling_flag;
  logic              cal_busy;
  logic              flg;
  int                errors   = 0;
  int                n_checks = 0;
  int                seed     = 88412;

  always #5 sys_clk = ~sys_clk;

  stage1_model #(.PERIOD(4)) src (.sys_clk(sys_clk), .reset_n(reset_n), .level(level),
    .stage1(stage1));
  second_stage_filter dut (.sys_clk(sys_clk), .reset_n(reset_n), .stage1(stage1),
    .addr(addr), .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata),
    .result(result), .step_settling_flag(step_settling_flag), .cal_busy(cal_busy));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wdata   <= d;
    wstrobe <= 1'b1;
    @(posedge sys_clk);
    wstrobe <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    addr    <= a;
    rstrobe <= 1'b1;
    @(posedge sys_clk);
    rstrobe <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask

  // Present one sample and capture the answer one cycle after it is taken
  task automatic smp(input logic [23:0] v);
    int k;
    @(posedge sys_clk);
    level <= v;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (stage1.valid && stage1.data === v)
        break;
    end
    if (k == 20)
    begin
      errors++;
      report_and_stop();
    end
    @(posedge sys_clk);
    #1;
    res = result;
    flg = step_settling_flag;
  endtask

  function automatic logic [23:0] corr(logic [23:0] x, o, g, logic w);
    logic [47:0] p;
    p = ({24'h0, x - o} * {24'h0, g}) >> 23;
    return w ? p[23:0] : {8'h00, p[23:8]};
  endfunction

  initial
  begin
    logic [23:0] o, g, x, d, c;
    int n;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rc(REG_FILTER, 32'hc, "filter");
    rc(REG_MODE, 32'h0, "mode");
    rc(REG_OFFSET, 32'h0, "offset");
    rc(REG_GAIN, 32'h800000, "gain");
    rc(REG_STATUS, 32'h0, "status");
    rc(8'h20, 32'h0, "unmapped");
    o = 24'($random(seed)) & 24'h0fffff;
    g = 24'($random(seed)) & 24'h7fffff;
    wr(REG_OFFSET, {8'hff, o});
    wr(REG_GAIN, {8'hff, g});
    rc(REG_OFFSET, {8'h0, o}, "offset rw");
    rc(REG_GAIN, {8'h0, g}, "gain rw");
    wr(REG_MODE, {29'h0, OP_CONT});
    for (int i = 0; i < 12; i++)
    begin
      if (i == 0 || i == 8)
        wr(REG_FILTER, i == 0 ? 32'hf : 32'h7);
      x = o + (24'($random(seed)) & 24'h3fffff);
      smp(x);
      `CHK("bypass valid", 1'b1, res.valid)
      `CHK("corrected", corr(x, o, g, i < 8), res.data)
      `CHK("bypass flag", 1'b0, flg)
    end
    wr(REG_OFFSET, 32'h0);
    wr(REG_GAIN, 32'h800000);
    for (int r = 0; r < 6; r++)
    begin
      wr(REG_FILTER, {28'h0, cfgs[r]});
      d = 24'h400000 + deltas[r];
      for (int j = 0; j < 30; j++)
        smp(24'h400000);
      `CHK("steady flag", 1'b0, flg)
      n = 0;
      for (int j = 0; j < 30; j++)
      begin
        smp(d);
        n += flg;
        if (flg && (j > 0 || !cfgs[r][2]))
          `CHK("step result", d, res.data)
      end
      `CHK("flag samples", nflag[r], n)
    end
    // Order: system zero before system full, zero after internal full
    for (int r = 0; r < 4; r++)
    begin
      c = 24'($random(seed)) & 24'h003fff;
      o = 24'($random(seed));
      g = 24'($random(seed));
      wr(REG_FILTER, r[0] ? 32'h8 : 32'hc);
      wr(REG_OFFSET, {8'h0, o});
      wr(REG_GAIN, {8'h0, g});
      wr(REG_MODE, {29'h0, OP_CONT});
      for (int j = 0; j < 30; j++)
        smp(c);
      wr(REG_MODE, {29'h0, cal_ops[r]});
      // Count every sample offered while busy, one launched at the write included
      n = 0;
      for (int k = 0; k < 400 && cal_busy === 1'b1; k++)
      begin
        if (stage1.valid)
          n++;
        @(posedge sys_clk);
        #1;
      end
      if (cal_busy !== 1'b0)
      begin
        errors++;
        report_and_stop();
      end
      `CHK("cal samples", cal_len[r], n)
      rc(REG_MODE, 32'h0, "mode idle");
      rc(REG_OFFSET, {8'h0, cal_ops[r] == OP_SYS_FULL ? o : c}, "cal offset");
      rc(REG_GAIN, {8'h0, cal_ops[r][0] ? c : g}, "cal gain");
    end
    // Single conversion: one corrected result, then back to idle
    wr(REG_OFFSET, 32'h0);
    wr(REG_GAIN, 32'h800000);
    wr(REG_MODE, {29'h0, OP_SINGLE});
    smp(c);
    smp(c);
    `CHK("single once", 1'b0, res.valid)
    rc(REG_RESULT, {8'h0, c}, "single result");
    rc(REG_MODE, 32'h0, "single idle");
    // Second channel keeps its own coefficients
    wr(REG_MODE, 32'h10);
    wr(REG_OFFSET, {8'h0, o});
    rc(REG_OFFSET, {8'h0, o}, "chan1 offset");
    wr(REG_MODE, 32'h0);
    rc(REG_OFFSET, 32'h0, "chan0 offset");
    report_and_stop();
  end
endmodule // second_stage_filter_tb_top

`default_nettype wire

// >>> tb/stage1_model.sv
// First-stage filter model: one sample pulse per output period
`default_nettype none

module stage1_model
  import filt_pkg::*;
#(
  parameter int PERIOD = 4
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [DATA_W-1:0] level,
  output var  sample_t           stage1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  wire        last = (cnt_q == 8'(PERIOD - 1));

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= 8'h00;
      stage1 <= '0;
    end
    else
    begin
      cnt_q        <= last ? 8'h00 : cnt_q + 8'h01;
      stage1.valid <= last;
      // Data is only meaningful with valid; scramble it otherwise
      stage1.data  <= last ? level : ~stage1.data;
    end
  end
endmodule // stage1_model

`default_nettype wire
